// [scmc_regs.vh]
// Register offsets, field positions, reset values and timing counts for the clock mode control
`ifndef SCMC_REGS_VH
`define SCMC_REGS_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SCMC_ADDR_W 2
`define SCMC_OFS_SYSCLK_CTRL 2'h0
`define SCMC_OFS_INT_RC_CTRL 2'h1
`define SCMC_OFS_FAST_XTAL_CTRL 2'h2
`define SCMC_OFS_SLOW_XTAL_CTRL 2'h3
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCMC_SYS_SEL_HI 7
`define SCMC_SYS_SEL_LO 5
`define SCMC_SYS_FAST_SRC 3
`define SCMC_SYS_SLOW_SRC 2
`define SCMC_SYS_HALT_FAST 1
`define SCMC_SYS_HALT_SLOW 0
`define SCMC_RC_FREQ_HI 3
`define SCMC_RC_FREQ_LO 2
`define SCMC_STABLE_BIT 1
`define SCMC_ENABLE_BIT 0
`define SCMC_XTAL_RANGE_BIT 2
// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define SCMC_SYSCLK_RST 8'h00
`define SCMC_RC_FREQ_RST 2'h0
`define SCMC_RC_EN_RST 1'b1
`define SCMC_SEL_SUBCLOCK 3'h7
// Operating modes
`define SCMC_MODE_FAST 3'h0
`define SCMC_MODE_SLOW 3'h1
`define SCMC_MODE_SLEEP 3'h2
`define SCMC_MODE_IDLE_SLOW 3'h3
`define SCMC_MODE_IDLE_BOTH 3'h4
`define SCMC_MODE_IDLE_FAST 3'h5
// ----------------------------------------------------------------
// Timing: start-up settle wait in core clock cycles
// ----------------------------------------------------------------
`define SCMC_SETTLE_CYCLES 1024
`endif

// [scmc_sync.v]
// Two-stage synchroniser for a level from another clock domain
`timescale 1ns/10ps
module scmc_sync
(
   input wire core_clk,
   input wire rst,
   input wire din,
   output wire dout
);
   reg meta_q;
   reg sync_q;
   // ----------------------------------------------------------------
   // Stage one is read by stage two only
   // ----------------------------------------------------------------
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end
   assign dout = sync_q;
endmodule

// [scmc_osc_stable.v]
// Stable flag tracker for one oscillator: cleared on enable, set after settle time
`timescale 1ns/10ps
`include "scmc_regs.vh"
module scmc_osc_stable
#(
   parameter SETTLE = `SCMC_SETTLE_CYCLES
)
(
   input wire core_clk,
   input wire rst,
   input wire enable,
   input wire enable_rise,
   input wire osc_ready,
   output reg stable
);
   reg [15:0] cnt_q;
   // ----------------------------------------------------------------
   // Settle counter
   // ----------------------------------------------------------------
   // A rising enable restarts the wait even if the flag was already high
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         cnt_q <= 16'h0000;
         stable <= 1'b0;
      end
      else if (!enable || enable_rise)
      begin
         cnt_q <= 16'h0000;
         stable <= 1'b0;
      end
      else if (!stable)
      begin
         if (osc_ready && (cnt_q >= SETTLE[15:0]))
            stable <= 1'b1;
         else if (cnt_q != 16'hffff)
            cnt_q <= cnt_q + 16'h0001;
      end
   end
endmodule

// [scmc_clock_mode.v]
// System clock select and low-power mode control with its four control registers
//
// Contract
// - Select field 0..6 picks fast clock divided 1..64; 7 picks subclock.
// - Fast source bit: 0 internal fast RC, 1 external fast crystal.
// - Slow source bit: 0 internal slow RC, 1 external slow crystal.
// - Fast mode clocks core from fast source divided by 1 to 64.
// - Halt with both halt enables low enters sleep; subclock stops.
// - Halt with fast low, slow high enters idle_slow_only.
// - Halt with both halt enables high enters idle_both_clocks.
// - Halt with fast high, slow low enters idle_fast_only.
// - Halt fast enable keeps fast oscillator running while core is off.
// - Halt slow enable keeps slow oscillator running while core is off.
// - Slow RC keeps running whenever watchdog is enabled, even in sleep.
// - In slow mode fast oscillator runs per its own enable bit.
// - RC frequency field: 00 4MHz, 01 8MHz, 10 12MHz, 11 4MHz.
// - Enabling the internal RC clears its stable flag, then sets it.
// - Internal RC enable turns it on or off; resets to one.
// - Unimplemented register bits read as zero.
// - Exactly six modes: fast, slow, sleep and three idle modes.
// - Enabling fast crystal clears its stable flag, then sets it.
// - Enabling slow crystal clears its stable flag, then sets it.
`timescale 1ns/10ps
`include "scmc_regs.vh"
module scmc_clock_mode
#(
   parameter SETTLE_CYCLES = `SCMC_SETTLE_CYCLES
)
(
   input wire core_clk,
   input wire rst,
   input wire [1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire halt_exec,
   input wire wake,
   input wire watchdog_enable,
   input wire fast_crystal_ok,
   input wire slow_crystal_ok,
   output reg core_run,
   output reg [2:0] op_mode,
   output reg [2:0] sys_div_sel,
   output reg sys_use_subclock,
   output reg sys_fast_source,
   output reg sub_slow_source,
   output reg fast_clock_on,
   output reg subclock_on,
   output reg slow_rc_on,
   output reg internal_fast_rc_on,
   output reg external_fast_crystal_on,
   output reg external_slow_crystal_on,
   output reg [1:0] int_rc_freq_out,
   output reg fast_crystal_range_out
);
   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   reg [2:0] sysclk_select_q;
   reg fast_source_select_q;
   reg slow_source_select_q;
   reg halt_fast_osc_enable_q;
   reg halt_slow_osc_enable_q;
   reg [1:0] int_rc_freq_select_q;
   reg int_rc_enable_q;
   reg fast_crystal_range_q;
   reg fast_crystal_enable_q;
   reg slow_crystal_enable_q;
   reg halted_q;
   reg [2:0] act_sel_q;
   reg act_fast_src_q;
   reg act_slow_src_q;
   reg [2:0] mode_d;
   reg [7:0] rdata_d;
   // Full register reset value; the select field is cut out of it by position
   localparam [7:0] SYS_RST = `SCMC_SYSCLK_RST;
   wire fast_ok_s;
   wire slow_ok_s;
   wire int_rc_stable_flag;
   wire fast_crystal_stable_flag;
   wire slow_crystal_stable_flag;
   wire wr_sys = reg_wr && (reg_addr == `SCMC_OFS_SYSCLK_CTRL);
   wire wr_rc = reg_wr && (reg_addr == `SCMC_OFS_INT_RC_CTRL);
   wire wr_fx = reg_wr && (reg_addr == `SCMC_OFS_FAST_XTAL_CTRL);
   wire wr_sx = reg_wr && (reg_addr == `SCMC_OFS_SLOW_XTAL_CTRL);
   wire rc_rise = wr_rc && reg_wdata[`SCMC_ENABLE_BIT] && !int_rc_enable_q;
   wire fx_rise = wr_fx && reg_wdata[`SCMC_ENABLE_BIT] && !fast_crystal_enable_q;
   wire sx_rise = wr_sx && reg_wdata[`SCMC_ENABLE_BIT] && !slow_crystal_enable_q;

   // ----------------------------------------------------------------
   // Crystal good levels arrive from the analog domain
   // ----------------------------------------------------------------
   scmc_sync u_sync_fast
   (
      .core_clk(core_clk),
      .rst(rst),
      .din(fast_crystal_ok),
      .dout(fast_ok_s)
   );
   scmc_sync u_sync_slow
   (
      .core_clk(core_clk),
      .rst(rst),
      .din(slow_crystal_ok),
      .dout(slow_ok_s)
   );

   // ----------------------------------------------------------------
   // Stable flags
   // ----------------------------------------------------------------
   // The RC has no ready pin, so only the settle count gates it
   scmc_osc_stable #(.SETTLE(SETTLE_CYCLES)) u_rc_stable
   (
      .core_clk(core_clk),
      .rst(rst),
      .enable(int_rc_enable_q),
      .enable_rise(rc_rise),
      .osc_ready(1'b1),
      .stable(int_rc_stable_flag)
   );
   scmc_osc_stable #(.SETTLE(SETTLE_CYCLES)) u_fx_stable
   (
      .core_clk(core_clk),
      .rst(rst),
      .enable(fast_crystal_enable_q),
      .enable_rise(fx_rise),
      .osc_ready(fast_ok_s),
      .stable(fast_crystal_stable_flag)
   );
   scmc_osc_stable #(.SETTLE(SETTLE_CYCLES)) u_sx_stable
   (
      .core_clk(core_clk),
      .rst(rst),
      .enable(slow_crystal_enable_q),
      .enable_rise(sx_rise),
      .osc_ready(slow_ok_s),
      .stable(slow_crystal_stable_flag)
   );

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         sysclk_select_q <= SYS_RST[`SCMC_SYS_SEL_HI:`SCMC_SYS_SEL_LO];
         fast_source_select_q <= 1'b0;
         slow_source_select_q <= 1'b0;
         halt_fast_osc_enable_q <= 1'b0;
         halt_slow_osc_enable_q <= 1'b0;
         int_rc_freq_select_q <= `SCMC_RC_FREQ_RST;
         int_rc_enable_q <= `SCMC_RC_EN_RST;
         fast_crystal_range_q <= 1'b0;
         fast_crystal_enable_q <= 1'b0;
         slow_crystal_enable_q <= 1'b0;
      end
      else
      begin
         if (wr_sys)
         begin
            sysclk_select_q <= reg_wdata[`SCMC_SYS_SEL_HI:`SCMC_SYS_SEL_LO];
            fast_source_select_q <= reg_wdata[`SCMC_SYS_FAST_SRC];
            slow_source_select_q <= reg_wdata[`SCMC_SYS_SLOW_SRC];
            halt_fast_osc_enable_q <= reg_wdata[`SCMC_SYS_HALT_FAST];
            halt_slow_osc_enable_q <= reg_wdata[`SCMC_SYS_HALT_SLOW];
         end
         if (wr_rc)
         begin
            int_rc_freq_select_q <= reg_wdata[`SCMC_RC_FREQ_HI:`SCMC_RC_FREQ_LO];
            int_rc_enable_q <= reg_wdata[`SCMC_ENABLE_BIT];
         end
         // Range is stored as written; software keeps it fixed while enabled
         if (wr_fx)
         begin
            fast_crystal_range_q <= reg_wdata[`SCMC_XTAL_RANGE_BIT];
            fast_crystal_enable_q <= reg_wdata[`SCMC_ENABLE_BIT];
         end
         if (wr_sx)
            slow_crystal_enable_q <= reg_wdata[`SCMC_ENABLE_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Glitch-free switch of the active selection
   // ----------------------------------------------------------------
   // Stable of a requested source: fast side by its source, slow RC always
   function src_ready;
      input [2:0] sel;
      input fsrc;
      input ssrc;
      input rc_ok;
      input fx_ok;
      input sx_ok;
      begin
         if (sel == `SCMC_SEL_SUBCLOCK)
            src_ready = ssrc ? sx_ok : 1'b1;
         else
            src_ready = fsrc ? fx_ok : rc_ok;
      end
   endfunction

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         act_sel_q <= SYS_RST[`SCMC_SYS_SEL_HI:`SCMC_SYS_SEL_LO];
         act_fast_src_q <= 1'b0;
         act_slow_src_q <= 1'b0;
      end
      else if (src_ready(sysclk_select_q, fast_source_select_q, slow_source_select_q,
               int_rc_stable_flag, fast_crystal_stable_flag, slow_crystal_stable_flag))
      begin
         // Old source stays in use until the new one reports stable
         act_sel_q <= sysclk_select_q;
         act_fast_src_q <= fast_source_select_q;
         act_slow_src_q <= slow_source_select_q;
      end
   end

   // ----------------------------------------------------------------
   // Halt and operating mode
   // ----------------------------------------------------------------
   always @(posedge core_clk)
   begin
      if (rst)
         halted_q <= 1'b0;
      else if (wake)
         halted_q <= 1'b0;
      else if (halt_exec)
         halted_q <= 1'b1;
   end

   always @*
   begin
      mode_d = `SCMC_MODE_FAST;
      if (!halted_q)
      begin
         if (act_sel_q == `SCMC_SEL_SUBCLOCK)
            mode_d = `SCMC_MODE_SLOW;
         else
            mode_d = `SCMC_MODE_FAST;
      end
      else
      begin
         case ({halt_fast_osc_enable_q, halt_slow_osc_enable_q})
            2'b00: mode_d = `SCMC_MODE_SLEEP;
            2'b01: mode_d = `SCMC_MODE_IDLE_SLOW;
            2'b11: mode_d = `SCMC_MODE_IDLE_BOTH;
            2'b10: mode_d = `SCMC_MODE_IDLE_FAST;
            default: mode_d = `SCMC_MODE_SLEEP;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Clock gating outputs
   // ----------------------------------------------------------------
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         core_run <= 1'b1;
         op_mode <= `SCMC_MODE_FAST;
         sys_div_sel <= 3'h0;
         sys_use_subclock <= 1'b0;
         sys_fast_source <= 1'b0;
         sub_slow_source <= 1'b0;
         fast_clock_on <= 1'b1;
         subclock_on <= 1'b1;
         slow_rc_on <= 1'b1;
         internal_fast_rc_on <= 1'b1;
         external_fast_crystal_on <= 1'b0;
         external_slow_crystal_on <= 1'b0;
         int_rc_freq_out <= `SCMC_RC_FREQ_RST;
         fast_crystal_range_out <= 1'b0;
      end
      else
      begin
         op_mode <= mode_d;
         core_run <= !halted_q;
         sys_div_sel <= act_sel_q;
         sys_use_subclock <= (act_sel_q == `SCMC_SEL_SUBCLOCK);
         sys_fast_source <= act_fast_src_q;
         sub_slow_source <= act_slow_src_q;
         // Running: fast clock on in fast mode, by its enable bit in slow mode
         if (!halted_q)
         begin
            if (act_sel_q == `SCMC_SEL_SUBCLOCK)
               fast_clock_on <= act_fast_src_q ? fast_crystal_enable_q
                                               : int_rc_enable_q;
            else
               fast_clock_on <= 1'b1;
            subclock_on <= 1'b1;
         end
         else
         begin
            fast_clock_on <= halt_fast_osc_enable_q;
            subclock_on <= halt_slow_osc_enable_q;
         end
         // Slow RC also serves the watchdog, so it never stops while that runs
         slow_rc_on <= !halted_q || halt_slow_osc_enable_q || watchdog_enable;
         internal_fast_rc_on <= int_rc_enable_q && (!halted_q || halt_fast_osc_enable_q);
         external_fast_crystal_on <= fast_crystal_enable_q;
         external_slow_crystal_on <= slow_crystal_enable_q;
         int_rc_freq_out <= int_rc_freq_select_q;
         fast_crystal_range_out <= fast_crystal_range_q;
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   always @*
   begin
      rdata_d = 8'h00;
      case (reg_addr)
         `SCMC_OFS_SYSCLK_CTRL: rdata_d = {sysclk_select_q, 1'b0, fast_source_select_q,
               slow_source_select_q, halt_fast_osc_enable_q, halt_slow_osc_enable_q};
         `SCMC_OFS_INT_RC_CTRL: rdata_d = {4'h0, int_rc_freq_select_q,
               int_rc_stable_flag, int_rc_enable_q};
         `SCMC_OFS_FAST_XTAL_CTRL: rdata_d = {5'h00, fast_crystal_range_q,
               fast_crystal_stable_flag, fast_crystal_enable_q};
         `SCMC_OFS_SLOW_XTAL_CTRL: rdata_d = {6'h00, slow_crystal_stable_flag,
               slow_crystal_enable_q};
         default: rdata_d = 8'h00;
      endcase
   end

   always @(posedge core_clk)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= rdata_d;
      else
         reg_rdata <= 8'h00;
   end
endmodule

// [scmc_clock_mode_properties.sv]
// Concurrent checks on the ports of the clock mode control block
`timescale 1ns/10ps
`include "scmc_regs.vh"
module scmc_clock_mode_properties
(
   input wire core_clk,
   input wire rst,
   input wire [1:0] reg_addr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire halt_exec,
   input wire wake,
   input wire watchdog_enable,
   input wire core_run,
   input wire [2:0] op_mode,
   input wire sys_use_subclock,
   input wire fast_clock_on,
   input wire subclock_on,
   input wire slow_rc_on
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_rc_upper_zero: assert property ($past(reg_rd) && $past(reg_addr) == 2'h1 |-> reg_rdata[7:4] == 4'h0)
      else $error("internal rc upper bits not zero");
   a_sys_bit4_zero: assert property ($past(reg_rd) && $past(reg_addr) == 2'h0 |-> !reg_rdata[4])
      else $error("system clock bit 4 not zero");
   a_run_modes: assert property (core_run |-> op_mode inside {`SCMC_MODE_FAST, `SCMC_MODE_SLOW})
      else $error("running core in a halted mode");
   a_off_modes: assert property (!core_run |-> op_mode inside {[`SCMC_MODE_SLEEP:`SCMC_MODE_IDLE_FAST]})
      else $error("halted core in a running mode");
   a_sleep_gates: assert property (op_mode == `SCMC_MODE_SLEEP |-> !fast_clock_on && !subclock_on)
      else $error("clock left on in sleep");
   a_idle_slow_gates: assert property (op_mode == `SCMC_MODE_IDLE_SLOW |-> !fast_clock_on && subclock_on)
      else $error("wrong gates in idle slow only");
   a_idle_both_gates: assert property (op_mode == `SCMC_MODE_IDLE_BOTH |-> fast_clock_on && subclock_on)
      else $error("wrong gates in idle both clocks");
   a_idle_fast_gates: assert property (op_mode == `SCMC_MODE_IDLE_FAST |-> fast_clock_on && !subclock_on)
      else $error("wrong gates in idle fast only");
   a_watchdog_rc_on: assert property (watchdog_enable [*3] |-> slow_rc_on)
      else $error("slow rc stopped with watchdog on");
   a_slow_mode_sub: assert property (core_run && sys_use_subclock |-> op_mode == `SCMC_MODE_SLOW)
      else $error("subclock in use outside slow mode");
   a_halt_stops: assert property (halt_exec && !wake |-> ##[1:3] !core_run)
      else $error("halt did not stop the core");
   a_wake_runs: assert property (wake |-> ##[1:3] core_run)
      else $error("wake did not restart the core");
endmodule
bind scmc_clock_mode scmc_clock_mode_properties u_props (.core_clk(core_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec),
   .wake(wake), .watchdog_enable(watchdog_enable), .core_run(core_run), .op_mode(op_mode),
   .sys_use_subclock(sys_use_subclock), .fast_clock_on(fast_clock_on),
   .subclock_on(subclock_on), .slow_rc_on(slow_rc_on));

// [system_clock_mode_control_tb_top.sv]
// Self-checking testbench for the system clock and mode control block
`timescale 1ns/10ps
`include "scmc_regs.vh"
module system_clock_mode_control_tb_top;
   logic core_clk, rst, reg_wr, reg_rd, halt_exec, wake;
   logic watchdog_enable, fast_crystal_ok, slow_crystal_ok;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, d;
   wire [7:0] reg_rdata;
   wire core_run, sys_use_subclock, sys_fast_source, sub_slow_source, fast_clock_on;
   wire subclock_on, slow_rc_on, internal_fast_rc_on, external_fast_crystal_on;
   wire external_slow_crystal_on, fast_crystal_range_out;
   wire [2:0] op_mode, sys_div_sel;
   wire [1:0] int_rc_freq_out;
   integer bad_count, num_checks, i;
   // Small settle count keeps the run short
   scmc_clock_mode #(.SETTLE_CYCLES(4)) u_dut (.core_clk(core_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .halt_exec(halt_exec), .wake(wake),
      .watchdog_enable(watchdog_enable), .fast_crystal_ok(fast_crystal_ok),
      .slow_crystal_ok(slow_crystal_ok), .core_run(core_run), .op_mode(op_mode),
      .sys_div_sel(sys_div_sel), .sys_use_subclock(sys_use_subclock),
      .sys_fast_source(sys_fast_source), .sub_slow_source(sub_slow_source),
      .fast_clock_on(fast_clock_on), .subclock_on(subclock_on), .slow_rc_on(slow_rc_on),
      .internal_fast_rc_on(internal_fast_rc_on),
      .external_fast_crystal_on(external_fast_crystal_on),
      .external_slow_crystal_on(external_slow_crystal_on),
      .int_rc_freq_out(int_rc_freq_out), .fast_crystal_range_out(fast_crystal_range_out));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task final_report;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
         bad_count = bad_count + 1;
         $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task rd(input logic [1:0] a, output logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   // Bounded poll of a stable flag; running out counts as a mismatch
   task wait_stable(input logic [1:0] a);
      integer k;
      k = 0;
      d = 8'h00;
      while (d[1] !== 1'b1 && k < 40)
      begin
         rd(a, d);
         k = k + 1;
      end
      if (d[1] !== 1'b1)
      begin
         bad_count = bad_count + 1;
         final_report();
      end
   endtask
   task pulse_halt(input logic w);
      @(posedge core_clk);
      if (w)
         wake <= 1'b1;
      else
         halt_exec <= 1'b1;
      @(posedge core_clk);
      wake <= 1'b0;
      halt_exec <= 1'b0;
      cyc(3);
   endtask
   // ----------------------------------------------------------------
   // Clock, reset and timeout
   // ----------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial
   begin
      #2000000;
      bad_count = bad_count + 1;
      final_report();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      bad_count = 0;
      num_checks = 0;
      rst = 1'b1;
      {reg_wr, reg_rd, halt_exec, wake, watchdog_enable} = 5'h00;
      {fast_crystal_ok, slow_crystal_ok} = 2'h0;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      chk({7'h00, core_run}, 8'h01, "core run after reset");
      chk({5'h00, op_mode}, {5'h00, `SCMC_MODE_FAST}, "mode after reset");
      chk({7'h00, internal_fast_rc_on}, 8'h01, "rc on after reset");
      wait_stable(2'h1);
      chk(d, 8'h03, "rc control reset");
      rd(2'h0, d);
      chk(d, 8'h00, "system control reset");
      rd(2'h2, d);
      chk(d, 8'h00, "fast crystal reset");
      rd(2'h3, d);
      chk(d, 8'h00, "slow crystal reset");
      $display("test reset values done");
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(2'h1, {4'hF, i[1:0], 2'h3});
         rd(2'h1, d);
         chk(d, {4'h0, i[1:0], 2'h3}, "rc control readback");
         chk({6'h00, int_rc_freq_out}, {6'h00, i[1:0]}, "rc frequency");
      end
      wr(2'h1, 8'h00);
      cyc(2);
      chk({7'h00, internal_fast_rc_on}, 8'h00, "rc off when disabled");
      wr(2'h1, 8'h01);
      rd(2'h1, d);
      chk(d, 8'h01, "rc flag cleared on enable");
      wait_stable(2'h1);
      chk({7'h00, internal_fast_rc_on}, 8'h01, "rc on after enable");
      $display("test internal rc done");
      wr(2'h0, 8'h10);
      rd(2'h0, d);
      chk(d, 8'h00, "system control bit 4");
      for (i = 0; i < 7; i = i + 1)
      begin
         wr(2'h0, {i[2:0], 5'h00});
         cyc(4);
         chk({5'h00, sys_div_sel}, {5'h00, i[2:0]}, "divide select");
         chk({7'h00, sys_use_subclock}, 8'h00, "fast clock in use");
      end
      wr(2'h0, 8'hE0);
      cyc(4);
      chk({4'h0, sys_use_subclock, op_mode}, {4'h1, `SCMC_MODE_SLOW}, "slow rc mode");
      chk({7'h00, sub_slow_source}, 8'h00, "slow rc source");
      wr(2'h0, 8'h00);
      cyc(4);
      chk({4'h0, sys_use_subclock, op_mode}, {4'h0, `SCMC_MODE_FAST}, "back to fast");
      $display("test clock select done");
      wr(2'h2, 8'h04);
      wr(2'h2, 8'h05);
      rd(2'h2, d);
      chk(d, 8'h05, "fast crystal flag cleared");
      chk({6'h00, external_fast_crystal_on, fast_crystal_range_out}, 8'h03, "fast crystal on");
      wr(2'h0, 8'h08);
      cyc(8);
      chk({7'h00, sys_fast_source}, 8'h00, "switch waits for crystal");
      fast_crystal_ok <= 1'b1;
      wait_stable(2'h2);
      chk(d, 8'h07, "fast crystal stable");
      cyc(4);
      chk({7'h00, sys_fast_source}, 8'h01, "fast crystal source");
      wr(2'h3, 8'hFF);
      rd(2'h3, d);
      chk(d, 8'h01, "slow crystal flag cleared");
      chk({7'h00, external_slow_crystal_on}, 8'h01, "slow crystal on");
      wr(2'h0, 8'hEC);
      cyc(8);
      chk({7'h00, sys_use_subclock}, 8'h00, "subclock waits for crystal");
      slow_crystal_ok <= 1'b1;
      wait_stable(2'h3);
      chk(d, 8'h03, "slow crystal stable");
      cyc(4);
      chk({6'h00, sys_use_subclock, sub_slow_source}, 8'h03, "slow crystal mode");
      chk({7'h00, fast_clock_on}, 8'h01, "fast kept by enable in slow");
      wr(2'h2, 8'h04);
      cyc(2);
      chk({7'h00, fast_clock_on}, 8'h00, "fast stopped by enable in slow");
      wr(2'h2, 8'h05);
      wait_stable(2'h2);
      wr(2'h0, 8'h08);
      cyc(4);
      $display("test crystals done");
      for (i = 0; i < 5; i = i + 1)
      begin
         watchdog_enable <= (i == 1);
         wr(2'h0, {6'h02, i >= 3, i == 2 || i == 3});
         pulse_halt(1'b0);
         chk({7'h00, core_run}, 8'h00, "core stopped");
         chk({5'h00, op_mode}, i < 2 ? 8'h02 : 8'h01 + i, "halted mode");
         chk({5'h00, internal_fast_rc_on, fast_clock_on, subclock_on},
            {5'h00, i >= 3, i >= 3, i == 2 || i == 3}, "halt gates");
         if (i < 2)
            chk({7'h00, slow_rc_on}, {7'h00, i == 1}, "slow rc in sleep");
         pulse_halt(1'b1);
         chk({4'h0, core_run, op_mode}, {4'h1, `SCMC_MODE_FAST}, "woken to fast");
      end
      $display("test halt modes done");
      final_report();
   end
endmodule
